// [ccm_regbank.v]
// register bank, reset-state logic and internal ram of the can controller
`default_nettype none
`include "ccm_consts.vh"

module ccm_regbank (
    input wire clock,
    input wire reset_n,
    input wire [7:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    output reg irq,
    input wire bus_off_in,
    input wire error_in,
    input wire tx_active_in,
    input wire rx_active_in,
    input wire tx_done_in,
    input wire tx_free_in,
    input wire overrun_in,
    input wire rx_full_in,
    input wire [7:0] irq_event,
    input wire [7:0] rx_msg_count_in,
    input wire rx_wr_en,
    input wire [5:0] rx_wr_addr,
    input wire [7:0] rx_wr_data,
    input wire [6:0] core_rd_addr,
    output reg [7:0] core_rd_data,
    output reg reset_mode_bit,
    output reg frame_abort,
    output reg sleep_request,
    output reg filter_single_select,
    output reg self_test_select,
    output reg listen_only_select,
    output reg [4:0] cmd_pulse,
    output reg [7:0] clock_divider_ctrl,
    output reg [5:0] rx_buffer_start
);

// ----------------------------------------
// state
// ----------------------------------------
reg [7:0] ram [0:`CCM_RAM_WORDS-1];
reg [7:0] status_r;
reg [7:0] irq_flags_r;
reg [7:0] irq_enable_r;
reg bus_off_d_r;
reg [7:0] rd_nxt;
reg [7:0] wr_byte;
reg [6:0] idx;
reg [5:0] fifo_ofs;
reg [6:0] ram_idx;
reg wr_go;
reg wr_ram;
reg reset_mode_nxt;
wire bus_off_rise;
wire reset_mode_enter;
wire [7:0] iclr;

always @*
begin
    idx = address[6:0]; // R08
    wr_byte = writedata[7:0];
    wr_go = write && !waitrequest && byteenable[0];
    fifo_ofs = rx_buffer_start + idx[5:0] - 6'h10; // R01
    ram_idx = idx - `CCM_IDX_RAM0;
    wr_ram = 1'b0;
    if (idx >= `CCM_IDX_RAM0 && idx <= `CCM_IDX_RAMN)
    begin
        wr_ram = wr_go && reset_mode_bit; // R04 R05 R06
    end
    else if (wr_go && !reset_mode_bit
             && (idx == `CCM_IDX_D7 || idx == `CCM_IDX_D8)
             && ram[`CCM_TXB_BASE][`CCM_FI_FF])
    begin
        wr_ram = 1'b1; // R01
        ram_idx = `CCM_TXB_BASE + idx - `CCM_IDX_FI;
    end
end

assign bus_off_rise = bus_off_in && !bus_off_d_r;
assign iclr = (wr_go && idx == `CCM_IDX_ICLR) ? wr_byte : 8'h00;

// ----------------------------------------
// mode and reset-mode entry
// ----------------------------------------
always @*
begin
    reset_mode_nxt = reset_mode_bit;
    if (wr_go && idx == `CCM_IDX_MODE)
    begin
        reset_mode_nxt = wr_byte[`CCM_MODE_RESET_BIT]; // R11
    end
    if (bus_off_rise)
    begin
        reset_mode_nxt = 1'b1; // R10
    end
end

assign reset_mode_enter = reset_mode_nxt && !reset_mode_bit;

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        reset_mode_bit <= 1'b1; // R12
        sleep_request <= 1'b0; // R12
        filter_single_select <= 1'b0; // R13
        self_test_select <= 1'b0; // R13
        listen_only_select <= 1'b0; // R13
        frame_abort <= 1'b0;
        bus_off_d_r <= 1'b0;
    end
    else
    begin
        bus_off_d_r <= bus_off_in;
        reset_mode_bit <= reset_mode_nxt;
        frame_abort <= reset_mode_enter; // R10
        if (reset_mode_enter)
        begin
            sleep_request <= 1'b0; // R12
        end
        else if (wr_go && idx == `CCM_IDX_MODE)
        begin
            sleep_request <= wr_byte[`CCM_MODE_SLEEP_BIT] && !reset_mode_bit;
        end
        if (wr_go && idx == `CCM_IDX_MODE && reset_mode_bit)
        begin
            filter_single_select <= wr_byte[`CCM_MODE_FILTER_BIT]; // R11
            self_test_select <= wr_byte[`CCM_MODE_SELFTEST_BIT];
            listen_only_select <= wr_byte[`CCM_MODE_LISTEN_BIT];
        end
    end
end

// ----------------------------------------
// commands, status, interrupts
// ----------------------------------------
always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        cmd_pulse <= 5'h00; // R14
        status_r <= `CCM_STAT_RST; // R15 R16
        irq_flags_r <= 8'h00; // R17 R18
        irq_enable_r <= 8'h00;
        irq <= 1'b0;
    end
    else
    begin
        cmd_pulse <= 5'h00;
        if (wr_go && idx == `CCM_IDX_CMD && !reset_mode_nxt)
        begin
            cmd_pulse <= wr_byte[4:0]; // R14
        end
        if (reset_mode_nxt)
        begin
            status_r <= (status_r & `CCM_STAT_KEEP) | `CCM_STAT_FORCE; // R16
        end
        else
        begin
            status_r <= {bus_off_in, error_in, tx_active_in, rx_active_in,
                         tx_done_in, tx_free_in, overrun_in, rx_full_in};
        end
        if (reset_mode_enter)
        begin
            irq_flags_r <= irq_flags_r & (8'h01 << `CCM_IRQ_WARN_BIT); // R17 R18
        end
        else
        begin
            irq_flags_r <= (irq_flags_r & ~iclr) | irq_event;
        end
        if (wr_go && idx == `CCM_IDX_IEN)
        begin
            irq_enable_r <= wr_byte;
        end
        irq <= |(irq_flags_r & irq_enable_r);
    end
end

// ----------------------------------------
// pointer and clock divider
// ----------------------------------------
always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        rx_buffer_start <= `CCM_RBSA_RST;
        clock_divider_ctrl <= `CCM_CDR_RST;
    end
    else
    begin
        if (wr_go && idx == `CCM_IDX_RBSA && reset_mode_bit)
        begin
            rx_buffer_start <= wr_byte[5:0]; // R02
        end
        if (wr_go && idx == `CCM_IDX_CDR)
        begin
            if (reset_mode_bit)
            begin
                clock_divider_ctrl <= wr_byte; // R03
            end
            else
            begin
                clock_divider_ctrl <= (clock_divider_ctrl & `CCM_CDR_LOCK)
                                      | (wr_byte & ~`CCM_CDR_LOCK); // R03
            end
        end
    end
end

// ----------------------------------------
// internal ram
// ----------------------------------------
always @(posedge clock)
begin
    if (wr_ram)
    begin
        ram[ram_idx] <= wr_byte;
    end
    else if (rx_wr_en)
    begin
        ram[{1'b0, rx_wr_addr}] <= rx_wr_data;
    end
end

always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        core_rd_data <= 8'h00;
    end
    else
    begin
        core_rd_data <= (core_rd_addr < `CCM_RAM_WORDS) ? ram[core_rd_addr] : 8'h00;
    end
end

// ----------------------------------------
// read decode
// ----------------------------------------
always @*
begin
    rd_nxt = 8'h00; // R07
    if (idx == `CCM_IDX_MODE)
    begin
        rd_nxt = {3'b000, sleep_request, filter_single_select, // R12
                  self_test_select, listen_only_select, reset_mode_bit};
    end
    else if (idx == `CCM_IDX_STAT)
    begin
        rd_nxt = status_r;
    end
    else if (idx == `CCM_IDX_IRQ)
    begin
        rd_nxt = irq_flags_r;
    end
    else if (idx == `CCM_IDX_IEN)
    begin
        rd_nxt = irq_enable_r;
    end
    else if ((idx == `CCM_IDX_D7 || idx == `CCM_IDX_D8) && !reset_mode_bit)
    begin
        rd_nxt = ram[{1'b0, fifo_ofs}]; // R01
    end
    else if (idx == `CCM_IDX_MCNT)
    begin
        rd_nxt = rx_msg_count_in;
    end
    else if (idx == `CCM_IDX_RBSA)
    begin
        rd_nxt = {2'b00, rx_buffer_start}; // R02
    end
    else if (idx == `CCM_IDX_CDR)
    begin
        rd_nxt = clock_divider_ctrl; // R03
    end
    else if (idx >= `CCM_IDX_RAM0 && idx <= `CCM_IDX_RAMN)
    begin
        rd_nxt = ram[idx - `CCM_IDX_RAM0]; // R04 R05 R06
    end
end

// ----------------------------------------
// avalon handshake
// ----------------------------------------
always @(posedge clock or negedge reset_n)
begin
    if (!reset_n)
    begin
        waitrequest <= 1'b1;
        readdata <= 32'h0000_0000;
    end
    else
    begin
        if (waitrequest && (read || write))
        begin
            waitrequest <= 1'b0;
            readdata <= {24'h00_0000, rd_nxt};
        end
        else
        begin
            waitrequest <= 1'b1;
        end
    end
end

endmodule // ccm_regbank
`default_nettype wire

// [ccm_consts.vh]
// constants for the can controller upper address map and reset block
// What this block does
// R01: addr 27-28 give fifo tail or tx data
// R02: addr 30 start pointer, write in reset only
// R03: addr 31 divider; mode bits reset-only writable
// R04: addr 32-95 map fifo ram 0-63
// R05: addr 96-108 map tx ram 64-76
// R06: addr 109-111 map free ram 77-79
// R07: addr 112-127 read zero, ignore writes
// R08: top address bit ignored, aliasing at 128
// R09: host avoids test register in operation
// R10: set reset bit aborts frame, enters reset
// R11: reset bit falling resumes configured mode
// R12: both resets clear sleep, set reset bit
// R13: hardware reset clears filter, test, listen bits
// R14: command bits zero after either reset
// R15: hardware reset status bus-on, ok, complete
// R16: both resets force idle, released, clear flags
// R17: interrupt flags except warning cleared by both resets
// R18: warning flag cleared by hardware reset or interrupt clear write, not software reset
`ifndef CCM_CONSTS_VH
`define CCM_CONSTS_VH
// ----------------------------------------
// register indexes (byte address is four times)
// ----------------------------------------
`define CCM_IDX_MODE 7'h00
`define CCM_IDX_CMD 7'h01
`define CCM_IDX_STAT 7'h02
`define CCM_IDX_IRQ 7'h03
`define CCM_IDX_IEN 7'h04
`define CCM_IDX_ICLR 7'h05
`define CCM_IDX_FI 7'h10
`define CCM_IDX_D7 7'h1b
`define CCM_IDX_D8 7'h1c
`define CCM_IDX_MCNT 7'h1d
`define CCM_IDX_RBSA 7'h1e
`define CCM_IDX_CDR 7'h1f
`define CCM_IDX_RAM0 7'h20
`define CCM_IDX_RAMN 7'h6f
`define CCM_TXB_BASE 7'h40
// ----------------------------------------
// field positions
// ----------------------------------------
`define CCM_MODE_RESET_BIT 0
`define CCM_MODE_LISTEN_BIT 1
`define CCM_MODE_SELFTEST_BIT 2
`define CCM_MODE_FILTER_BIT 3
`define CCM_MODE_SLEEP_BIT 4
`define CCM_IRQ_WARN_BIT 2
`define CCM_FI_FF 7
`define CCM_CDR_LOCK 8'he8
// ----------------------------------------
// reset values and ram size
// ----------------------------------------
`define CCM_MODE_RST 5'h01
`define CCM_STAT_RST 8'h3c
`define CCM_STAT_KEEP 8'hc8
`define CCM_STAT_FORCE 8'h34
`define CCM_CDR_RST 8'h00
`define CCM_RBSA_RST 6'h00
`define CCM_RAM_WORDS 80
`endif

// [ccm_regbank_checker.sv]
// assertions on the register bank ports
`default_nettype none
module ccm_regbank_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [6:0] core_rd_addr,
    input wire logic [7:0] core_rd_data,
    input wire logic reset_mode_bit,
    input wire logic frame_abort,
    input wire logic sleep_request,
    input wire logic [4:0] cmd_pulse,
    input wire logic [7:0] clock_divider_ctrl,
    input wire logic [5:0] rx_buffer_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_ack_next: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered next cycle");
    chk_ack_once: assert property (!waitrequest |=> waitrequest)
        else $error("answer held too long");
    chk_abort_entry: assert property ($rose(reset_mode_bit) |-> ##[0:1] frame_abort)
        else $error("no abort on reset mode entry");
    chk_sleep_off: assert property (reset_mode_bit && $past(reset_mode_bit) |-> !sleep_request)
        else $error("sleep set in reset mode");
    chk_cmd_quiet: assert property (reset_mode_bit |-> cmd_pulse == 5'h0)
        else $error("command pulse in reset mode");
    chk_start_lock: assert property (!reset_mode_bit && !$past(reset_mode_bit) |-> $stable(rx_buffer_start))
        else $error("start pointer changed in operating mode");
    chk_div_lock: assert property (!reset_mode_bit && !$past(reset_mode_bit)
        |-> (clock_divider_ctrl & 8'he8) == ($past(clock_divider_ctrl) & 8'he8))
        else $error("locked divider bits changed");
    chk_zero_read: assert property (read && !waitrequest && address[6:4] == 3'h7
        |-> readdata == 32'h0000_0000)
        else $error("upper range read not zero");
    chk_core_far: assert property (core_rd_addr > 7'h4f |=> core_rd_data == 8'h00)
        else $error("core read beyond ram not zero");
endmodule // ccm_regbank_checker
bind ccm_regbank ccm_regbank_checker i_chk (.clock, .reset_n, .address, .read, .write,
    .readdata, .waitrequest, .core_rd_addr, .core_rd_data, .reset_mode_bit, .frame_abort,
    .sleep_request, .cmd_pulse, .clock_divider_ctrl, .rx_buffer_start);
`default_nettype wire

// [ccm_core_model.sv]
// core-side model feeding status levels, events and ram reads
`default_nettype none
module ccm_core_model (
    input wire logic clock,
    input wire logic [7:0] ev_req,
    output var logic [7:0] irq_event,
    output var logic [7:0] status_lv,
    output var logic [6:0] core_rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial irq_event = 8'h00;
    initial core_rd_addr = 7'h00;
    assign status_lv = 8'h4c;
    always @(posedge clock)
    begin
        irq_event <= ev_req;
        core_rd_addr <= core_rd_addr + 7'h01;
    end
endmodule // ccm_core_model
`default_nettype wire

// [testbench.sv]
// self-checking testbench of the register bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic [7:0] ev_req = 8'h00;
    logic [7:0] irq_event;
    logic [7:0] status_lv;
    logic [6:0] core_rd_addr;
    int miscompares = 0;
    int n_checks = 0;
    always #2.5 clock = ~clock;
    ccm_core_model i_core (.clock, .ev_req, .irq_event, .status_lv, .core_rd_addr);
    ccm_regbank i_dut (.clock, .reset_n, .address, .read, .write, .byteenable(4'h1),
        .writedata, .readdata, .waitrequest, .irq, .bus_off_in(status_lv[7]),
        .error_in(status_lv[6]), .tx_active_in(status_lv[5]), .rx_active_in(status_lv[4]),
        .tx_done_in(status_lv[3]), .tx_free_in(status_lv[2]), .overrun_in(status_lv[1]),
        .rx_full_in(status_lv[0]), .irq_event, .rx_msg_count_in(8'h00), .rx_wr_en(1'b0),
        .rx_wr_addr(6'h00), .rx_wr_data(8'h00), .core_rd_addr, .core_rd_data(),
        .reset_mode_bit(), .frame_abort(), .sleep_request(), .filter_single_select(),
        .self_test_select(), .listen_only_select(), .cmd_pulse(), .clock_divider_ctrl(),
        .rx_buffer_start());
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h00_0000, d};
        read <= rd;
        write <= !rd;
        do
        begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            complete_run();
        end
        if (rd)
            check(readdata[7:0], d);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b1, a, e);
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(8'h00, 8'h01);
        rd(8'h02, 8'h3c);
        rd(8'h03, 8'h00);
        rd(8'h01, 8'h00);
        // the production test register index is never accessed
        $display("test reset values done");
        wr(8'h1e, 8'h15);
        rd(8'h1e, 8'h15);
        wr(8'ha0, 8'ha5);
        rd(8'h20, 8'ha5);
        wr(8'h40, 8'hc3);
        wr(8'h68, 8'h5a);
        rd(8'h68, 8'h5a);
        wr(8'h6f, 8'h3c);
        rd(8'h6f, 8'h3c);
        wr(8'h7f, 8'hff);
        rd(8'h7f, 8'h00);
        wr(8'h1f, 8'hff);
        rd(8'h1f, 8'hff);
        $display("test reset mode map done");
        wr(8'h00, 8'h0f);
        wr(8'h00, 8'h0e);
        rd(8'h00, 8'h0e);
        rd(8'h02, 8'h4c);
        wr(8'h1e, 8'h3f);
        rd(8'h1e, 8'h15);
        wr(8'h20, 8'h00);
        rd(8'h20, 8'ha5);
        wr(8'h1f, 8'h00);
        rd(8'h1f, 8'he8);
        rd(8'h1b, 8'hc3);
        $display("test operating map done");
        wr(8'h04, 8'h04);
        ev_req <= 8'h05;
        @(posedge clock);
        ev_req <= 8'h00;
        repeat (3) @(posedge clock);
        rd(8'h03, 8'h05);
        check({7'h00, irq}, 8'h01);
        wr(8'h00, 8'h0f);
        rd(8'h03, 8'h04);
        rd(8'h02, 8'h7c);
        rd(8'h00, 8'h0f);
        wr(8'h05, 8'h04);
        rd(8'h03, 8'h00);
        check({7'h00, irq}, 8'h00);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(8'h00, 8'h01);
        $display("test interrupts and resets done");
        complete_run();
    end
endmodule // testbench
`default_nettype wire
